/* File: src/swsci_pkg.sv */
/*
 * Shared constants and types of the single-wire slave command interface.
 * Assumes a 50 MHz system clock; all slot timing is derived from it.
 */
package swsci_pkg;
  localparam int unsigned CLK_FREQ_MHZ = 50;
  localparam int unsigned CNT_W = 16;
  // Times in microseconds.
  localparam int unsigned T_SAMPLE_US = 30;
  localparam int unsigned T_RD_HOLD_US = 30;
  localparam int unsigned T_RSTL_US = 480;
  localparam int unsigned T_PDH_US = 30;
  localparam int unsigned T_PDL_US = 120;
  localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(T_SAMPLE_US * CLK_FREQ_MHZ);
  localparam logic [CNT_W-1:0] RD_HOLD_CYC = CNT_W'(T_RD_HOLD_US * CLK_FREQ_MHZ);
  localparam logic [CNT_W-1:0] PDH_CYC = CNT_W'(T_PDH_US * CLK_FREQ_MHZ);
  localparam logic [CNT_W-1:0] RSTL_CYC_DEF = CNT_W'(T_RSTL_US * CLK_FREQ_MHZ);
  localparam logic [CNT_W-1:0] PDL_CYC_DEF = CNT_W'(T_PDL_US * CLK_FREQ_MHZ);
  localparam logic [CNT_W-1:0] SLOT_DONE_CYC = (SAMPLE_CYC > RD_HOLD_CYC) ?
                                               SAMPLE_CYC : RD_HOLD_CYC;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  // Function opcodes.
  localparam logic [7:0] OP_READ = 8'h69;
  localparam logic [7:0] OP_WRITE = 8'h6c;
  localparam logic [7:0] OP_COPY = 8'h48;
  localparam logic [7:0] OP_RECALL = 8'hb8;
  localparam logic [7:0] OP_LOCK = 8'h6a;
  localparam logic [7:0] OP_REFRESH = 8'h63;
  localparam logic [7:0] OP_CHG_START = 8'hb5;
  localparam logic [7:0] OP_CHG_STOP = 8'hbe;
  // Memory layout.
  localparam logic [7:0] STATUS_INIT_ADDR = 8'h31;
  localparam logic [7:0] EE_FIRST = 8'h20;
  localparam logic [7:0] EE_LAST = 8'h4f;
  localparam logic [7:0] EE_BLK_STEP = 8'h10;
  localparam int unsigned EE_BLOCKS = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Write buffer shape.
  localparam int unsigned FIFO_W = 16;
  localparam int unsigned FIFO_D = 16;

  typedef enum logic [3:0] {
    ST_WAIT_RST, ST_PDH, ST_PDL, ST_NET, ST_FUNC, ST_ADDR, ST_READ, ST_WRITE, ST_DONE
  } swsci_state_t;
endpackage

/* File: src/swsci_fifo.sv */
/*
 * Small FIFO with valid/ready on both sides and a registered read port.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module swsci_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned D = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign push = in_valid_i & in_ready_o;
  assign pop = (cnt_q != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= AW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= AW'(rp_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // The output register is a further entry, so a stalled sink still sees data.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem_q[rp_q];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

/* File: src/swsci_slave.sv */
/*
 * Slave end of a single-wire open-drain command bus: reset and presence,
 * write and read slots, and function command decoding.
 * Assumes dq_i is synchronous to clk_i, a memory whose read data follow
 * mem_rd_o by one cycle, and an EEPROM/charger controller that acts on the
 * command pulses.
 */
// Overview of operation
// - Four signal types; only presence is driven by the device unprompted.
// - Reset pulse is answered with presence before any command is accepted.
// - After reset rises, wait presence-high delay, then drive presence low.
// - Device samples write slots 15 to 60 us after the fall.
// - Read data valid on the line by 15 us after slot start.
// - Device releases line by end of read slot.
// - Read and write data commands take an address, then stream bytes.
// - Recall reloads shadow RAM from a block, then awaits reset.
// - Copy ignored when locked; busy flag blocks EEPROM writes meanwhile.
// - Lock acts only with lock enable and as first command after reset.
// - Refresh reloads status from EEPROM byte at location 31h.
// - Dedicated opcodes start and stop charging.
`timescale 1ns/10ps
module swsci_slave
  import swsci_pkg::*;
#(
  parameter logic [CNT_W-1:0] RSTL_CYC = RSTL_CYC_DEF,
  parameter logic [CNT_W-1:0] PDL_CYC = PDL_CYC_DEF,
  parameter logic [CNT_W-1:0] SMP_CYC = SAMPLE_CYC,
  parameter logic [CNT_W-1:0] HOLD_CYC = RD_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_o,
  output logic [7:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_rdata_i,
  output logic wr_valid_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  input wire logic wr_ready_i,
  input wire logic copy_busy_flag_i,
  input wire logic lock_enable_i,
  input wire logic [2:0] blk_locked_i,
  output logic copy_o,
  output logic recall_o,
  output logic lock_o,
  output logic refresh_o,
  output logic chg_start_o,
  output logic chg_stop_o,
  output logic [7:0] blk_addr_o
);
  // A slot window closes once both its sample point and its read hold have passed.
  localparam logic [CNT_W-1:0] DONE_CYC = (SMP_CYC > HOLD_CYC) ? SMP_CYC : HOLD_CYC;
  swsci_state_t state_q;
  logic dq_q, fall, rise, rst_seen_q, bus_reset;
  logic [CNT_W-1:0] low_cnt_q, slot_cnt_q, tmr_q;
  logic slot_act_q, rx_state, rx_tick, tx_tick, last_bit;
  logic [2:0] bit_cnt_q;
  logic [7:0] sh_q, rx_byte, op_q, addr_q, tx_q;
  logic rd_wait_q, lock_arm_q, wr_pend_q, wr_take, fifo_rdy;
  logic [FIFO_W-1:0] wr_word_q, fifo_out;

  function automatic logic is_eeprom(input logic [7:0] a);
    return (a >= EE_FIRST) && (a <= EE_LAST);
  endfunction

  function automatic logic blk_ok(input logic [7:0] a, input logic [2:0] lk);
    blk_ok = 1'b0;
    for (int i = 0; i < EE_BLOCKS; i++) begin
      if (a == EE_FIRST + 8'(i) * EE_BLK_STEP) begin
        blk_ok = ~lk[i];
      end
    end
  endfunction

  assign fall = dq_q & ~dq_i;
  assign rise = ~dq_q & dq_i;
  assign bus_reset = rise & rst_seen_q;
  assign rx_state = (state_q == ST_NET) || (state_q == ST_FUNC) ||
                    (state_q == ST_ADDR) || (state_q == ST_WRITE);
  assign rx_tick = slot_act_q && (slot_cnt_q == SMP_CYC) && rx_state;
  assign tx_tick = slot_act_q && (slot_cnt_q == HOLD_CYC) && (state_q == ST_READ);
  assign last_bit = (bit_cnt_q == BIT_LAST);
  assign rx_byte = {dq_i, sh_q[7:1]};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dq_q <= 1'b1;
      dq_o <= 1'b0;
    end else begin
      dq_q <= dq_i;
      dq_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_cnt_q <= CNT_ZERO;
      rst_seen_q <= 1'b0;
    end else begin
      if (dq_i) begin
        low_cnt_q <= CNT_ZERO;
      end else if (low_cnt_q != CNT_MAX) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
      if (rise) begin
        rst_seen_q <= 1'b0;
      end else if (!dq_i && low_cnt_q == RSTL_CYC) begin
        rst_seen_q <= 1'b1;
      end
    end
  end

  // slot timing from the falling edge
  // Our own presence pulse is not a slot; timing it could clock in a bogus bit.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || bus_reset) begin
      slot_act_q <= 1'b0;
      slot_cnt_q <= CNT_ZERO;
    end else if (fall && state_q != ST_PDL) begin
      slot_act_q <= 1'b1;
      slot_cnt_q <= CNT_ZERO;
    end else if (slot_act_q) begin
      slot_cnt_q <= slot_cnt_q + 1'b1;
      if (slot_cnt_q == DONE_CYC) begin
        slot_act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || bus_reset || (state_q == ST_PDH && tmr_q == PDH_CYC)) begin
      tmr_q <= CNT_ZERO;
    end else if (tmr_q != CNT_MAX) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_WAIT_RST;
      op_q <= RST_BYTE;
    end else if (bus_reset) begin
      state_q <= ST_PDH;
    end else begin
      unique case (state_q)
        ST_WAIT_RST, ST_READ, ST_WRITE, ST_DONE: begin
        end
        ST_PDH: if (tmr_q == PDH_CYC) state_q <= ST_PDL;
        ST_PDL: if (tmr_q == PDL_CYC) state_q <= ST_NET;
        ST_NET: if (rx_tick && last_bit) state_q <= ST_FUNC;
        ST_FUNC: begin
          if (rx_tick && last_bit) begin
            op_q <= rx_byte;
            case (rx_byte)
              OP_READ, OP_WRITE, OP_COPY, OP_RECALL, OP_LOCK: state_q <= ST_ADDR;
              default: state_q <= ST_DONE;
            endcase
          end
        end
        ST_ADDR: begin
          if (rx_tick && last_bit) begin
            if (op_q == OP_READ) begin
              state_q <= ST_READ;
            end else if (op_q == OP_WRITE) begin
              state_q <= ST_WRITE;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || bus_reset) begin
      bit_cnt_q <= 3'h0;
      sh_q <= RST_BYTE;
    end else if (rx_tick) begin
      sh_q <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end else if (tx_tick) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_q <= RST_BYTE;
      tx_q <= RST_BYTE;
      rd_wait_q <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= RST_BYTE;
    end else begin
      mem_rd_o <= 1'b0;
      rd_wait_q <= mem_rd_o;
      if (rd_wait_q) begin
        tx_q <= mem_rdata_i;
      end else if (tx_tick) begin
        tx_q <= {1'b0, tx_q[7:1]};
      end
      if (state_q == ST_ADDR && rx_tick && last_bit) begin
        addr_q <= rx_byte;
        mem_addr_o <= rx_byte;
        mem_rd_o <= (op_q == OP_READ);
      end else if (tx_tick && last_bit) begin
        addr_q <= addr_q + 1'b1;
        mem_addr_o <= addr_q + 1'b1;
        mem_rd_o <= 1'b1;
      end else if (state_q == ST_WRITE && rx_tick && last_bit) begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dq_oe_o <= 1'b0;
    end else if (state_q == ST_PDH && tmr_q == PDH_CYC) begin
      dq_oe_o <= 1'b1;
    end else if (state_q == ST_PDL) begin
      dq_oe_o <= (tmr_q != PDL_CYC);
    end else if (state_q == ST_READ && fall) begin
      dq_oe_o <= ~tx_q[0];
    end else if (tx_tick || state_q != ST_READ) begin
      dq_oe_o <= 1'b0;
    end
  end

  assign wr_take = (state_q == ST_WRITE) && rx_tick && last_bit &&
                   !(is_eeprom(addr_q) && copy_busy_flag_i) && (!wr_pend_q || fifo_rdy);

  // A full buffer holds one byte here; a further byte arriving meanwhile is lost.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_word_q <= '0;
    end else begin
      if (fifo_rdy) begin
        wr_pend_q <= 1'b0;
      end
      if (wr_take) begin
        wr_pend_q <= 1'b1;
        wr_word_q <= {addr_q, rx_byte};
      end
    end
  end

  swsci_fifo #(.W(FIFO_W), .D(FIFO_D)) u_wr_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_pend_q),
    .in_data_i(wr_word_q),
    .in_ready_o(fifo_rdy),
    .out_valid_o(wr_valid_o),
    .out_data_o(fifo_out),
    .out_ready_i(wr_ready_i)
  );
  assign wr_addr_o = fifo_out[15:8];
  assign wr_data_o = fifo_out[7:0];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || bus_reset) begin
      lock_arm_q <= 1'b1;
    end else if (state_q == ST_FUNC && rx_tick && last_bit && rx_byte != OP_LOCK) begin
      lock_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {copy_o, recall_o, lock_o, refresh_o, chg_start_o, chg_stop_o} <= 6'h00;
      blk_addr_o <= RST_BYTE;
    end else begin
      {copy_o, recall_o, lock_o, refresh_o, chg_start_o, chg_stop_o} <= 6'h00;
      if (state_q == ST_ADDR && rx_tick && last_bit) begin
        blk_addr_o <= rx_byte;
        copy_o <= (op_q == OP_COPY) && blk_ok(rx_byte, blk_locked_i) && !copy_busy_flag_i;
        recall_o <= (op_q == OP_RECALL) && is_eeprom(rx_byte);
        lock_o <= (op_q == OP_LOCK) && lock_arm_q && lock_enable_i &&
                  blk_ok(rx_byte, blk_locked_i);
      end else if (state_q == ST_FUNC && rx_tick && last_bit) begin
        refresh_o <= (rx_byte == OP_REFRESH);
        if (rx_byte == OP_REFRESH) begin
          blk_addr_o <= STATUS_INIT_ADDR;
        end
        chg_start_o <= (rx_byte == OP_CHG_START);
        chg_stop_o <= (rx_byte == OP_CHG_STOP);
      end
    end
  end

  property p_reset_seen;
    @(posedge clk_i) disable iff (!rst_n_i) (!dq_i && low_cnt_q == RSTL_CYC) |=> rst_seen_q;
  endproperty
  a_reset_seen: assert property (p_reset_seen) else $error("reset not recognised");
  property p_presence_follows;
    @(posedge clk_i) disable iff (!rst_n_i) bus_reset |=> (state_q == ST_PDH) && !dq_oe_o;
  endproperty
  a_presence_follows: assert property (p_presence_follows) else $error("no presence");
  property p_pdh_quiet;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(state_q == ST_PDH) |-> !dq_oe_o [*8];
  endproperty
  a_pdh_quiet: assert property (p_pdh_quiet) else $error("line driven in wait");
  property p_pdl_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(state_q == ST_PDL) |-> dq_oe_o && $past(tmr_q) == PDH_CYC;
  endproperty
  a_pdl_drive: assert property (p_pdl_drive) else $error("presence low late");
  property p_rx_sample;
    @(posedge clk_i) disable iff (!rst_n_i) rx_tick |=> sh_q[7] == $past(dq_i);
  endproperty
  a_rx_sample: assert property (p_rx_sample) else $error("bit not sampled");
  property p_rd_valid;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_READ && fall && !tx_q[0]) |=> dq_oe_o [*8];
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("zero bit not driven");
  property p_rd_release;
    @(posedge clk_i) disable iff (!rst_n_i) tx_tick |=> !dq_oe_o;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("line held past slot");
  property p_read_fetch;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_ADDR && rx_tick && last_bit && op_q == OP_READ)
        |=> mem_rd_o ##2 tx_q == $past(mem_rdata_i);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("read fetch missing");
  property p_recall_end;
    @(posedge clk_i) disable iff (!rst_n_i) recall_o |-> state_q == ST_DONE;
  endproperty
  a_recall_end: assert property (p_recall_end) else $error("recall not final");
  property p_done_quiet;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_DONE && fall) |=> (state_q == ST_DONE && !dq_oe_o) [*4];
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("slot served after end");
  property p_copy_gate;
    @(posedge clk_i) disable iff (!rst_n_i) copy_o |-> $past(!copy_busy_flag_i);
  endproperty
  a_copy_gate: assert property (p_copy_gate) else $error("copy while busy");
  property p_lock_gate;
    @(posedge clk_i) disable iff (!rst_n_i) lock_o |-> $past(lock_enable_i && lock_arm_q);
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("lock without enable");
  property p_refresh_src;
    @(posedge clk_i) disable iff (!rst_n_i) refresh_o |-> blk_addr_o == STATUS_INIT_ADDR;
  endproperty
  a_refresh_src: assert property (p_refresh_src) else $error("refresh source wrong");
  property p_chg_start;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == ST_FUNC && rx_tick && last_bit && rx_byte == OP_CHG_START)
        |=> chg_start_o ##1 !chg_start_o;
  endproperty
  a_chg_start: assert property (p_chg_start) else $error("charge start missing");
endmodule

/* File: bench/swsci_master.sv */
/*
 * Behavioural bus master for the single-wire slave: reset pulse, write and
 * read slots. Assumes the testbench resolves the line with a pull-up.
 */
`timescale 1ns/10ps
module swsci_master #(
  parameter int RST_LOW = 300,
  parameter int SLOT = 130
) (
  input wire logic clk_i,
  input wire logic dq_i,
  output logic oe_o
);
  // Slots are scaled down with the slave's 100-cycle sample point to keep the run brief.
  localparam int REC = 50;
  initial oe_o = 1'b0;

  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic bus_reset(output int dly, output int wid);
    dly = -1;
    wid = 0;
    oe_o = 1'b1;
    hold(RST_LOW);
    oe_o = 1'b0;
    for (int i = 0; i < 4000 && dly < 0; i++) begin
      hold(1);
      if (dq_i === 1'b0) dly = i + 1;
    end
    while (dly >= 0 && dq_i === 1'b0 && wid < 4000) begin
      hold(1);
      wid++;
    end
    hold(100);
  endtask

  task automatic write_bit(input logic b);
    oe_o = 1'b1;
    hold(b ? 50 : SLOT);
    oe_o = 1'b0;
    hold(b ? SLOT - 50 + REC : REC);
  endtask

  // read slot, sampled 75 cycles in
  task automatic read_bit(output logic b, output logic rel);
    oe_o = 1'b1;
    hold(50);
    oe_o = 1'b0;
    hold(25);
    b = dq_i;
    hold(SLOT - 75);
    rel = dq_i;
    hold(REC);
  endtask

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]);
  endtask

  task automatic read_byte(output logic [7:0] v, output logic rel);
    logic b;
    logic r;
    rel = 1'b1;
    for (int i = 0; i < 8; i++) begin
      read_bit(b, r);
      v[i] = b;
      rel = rel & r;
    end
  endtask
endmodule

/* File: bench/testbench.sv */
/*
 * Self-checking bench for swsci_slave with a master model, a one-cycle
 * memory and a randomly stalling write sink. Assumes a 50 MHz clock.
 */
`timescale 1ns/10ps
module testbench;
  import swsci_pkg::*;
  // Scaled timing; the reset threshold must exceed every low that a slot holds.
  localparam logic [CNT_W-1:0] RSTL = 16'h00c8;
  localparam logic [CNT_W-1:0] PDL = 16'h003c;
  localparam logic [CNT_W-1:0] SMP = 16'h0064;
  localparam logic [CNT_W-1:0] HOLD = 16'h0064;
  logic clk_i, rst_n_i, dq, m_oe, dq_o, dq_oe_o, mem_rd_o, wr_valid_o, wr_ready_i;
  logic copy_busy_flag_i, lock_enable_i;
  logic copy_o, recall_o, lock_o, refresh_o, chg_start_o, chg_stop_o;
  logic [2:0] blk_locked_i;
  logic [7:0] mem_addr_o, mem_rdata_i, wr_addr_o, wr_data_o, blk_addr_o, v;
  logic [23:0] exp_q[$];
  logic rel;
  int n_fail, cmp_count;

  // Open-drain line with pull-up: low when any party drives.
  assign dq = ~(dq_oe_o | m_oe);

  swsci_slave #(.RSTL_CYC(RSTL), .PDL_CYC(PDL), .SMP_CYC(SMP), .HOLD_CYC(HOLD)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .dq_i(dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
    .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_ready_i(wr_ready_i), .copy_busy_flag_i(copy_busy_flag_i),
    .lock_enable_i(lock_enable_i), .blk_locked_i(blk_locked_i), .copy_o(copy_o),
    .recall_o(recall_o), .lock_o(lock_o), .refresh_o(refresh_o),
    .chg_start_o(chg_start_o), .chg_stop_o(chg_stop_o), .blk_addr_o(blk_addr_o));

  swsci_master m (.clk_i(clk_i), .dq_i(dq), .oe_o(m_oe));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Memory answers one cycle after the read request.
  always @(negedge clk_i) begin
    if (mem_rd_o === 1'b1) mem_rdata_i <= mem_addr_o ^ 8'ha5;
    wr_ready_i <= 1'($urandom_range(0, 1));
  end

  task automatic note_seen(input logic [23:0] ev);
    if (exp_q.size() == 0) begin
      check("unexpected event", ev, 24'h0);
    end else begin
      check("event", ev, exp_q.pop_front());
    end
  endtask

  // Outputs are sampled before the edge's updates land.
  always @(posedge clk_i) begin
    if (rst_n_i === 1'b1) begin
      if (wr_valid_o && wr_ready_i) note_seen({8'h01, wr_addr_o, wr_data_o});
      if (mem_rd_o) note_seen({8'h02, mem_addr_o, 8'h00});
      if (copy_o) note_seen({8'h10, blk_addr_o, 8'h00});
      if (recall_o) note_seen({8'h11, blk_addr_o, 8'h00});
      if (lock_o) note_seen({8'h12, blk_addr_o, 8'h00});
      if (refresh_o) note_seen({8'h13, blk_addr_o, 8'h00});
      if (chg_start_o) note_seen({8'h14, 8'h00, 8'h00});
      if (chg_stop_o) note_seen({8'h15, 8'h00, 8'h00});
    end
  end

  task automatic start(input logic [7:0] op);
    int d;
    int w;
    m.bus_reset(d, w);
    check("presence delay in range", 24'(d >= 750 && d <= 3000), 24'h1);
    check("presence width", 24'(w >= PDL && w <= PDL + 2), 24'h1);
    m.write_byte(8'($urandom));
    m.write_byte(op);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic use_a,
                     input logic le, input logic [2:0] lk, input logic [7:0] kind);
    lock_enable_i = le;
    blk_locked_i = lk;
    if (kind != 8'h00) exp_q.push_back({kind, (kind > 8'h13) ? 8'h00 : a, 8'h00});
    start(op);
    if (use_a) m.write_byte(a);
  endtask

  initial begin
    void'($urandom(97));
    rst_n_i = 1'b0;
    mem_rdata_i = 8'h00;
    wr_ready_i = 1'b0;
    copy_busy_flag_i = 1'b0;
    lock_enable_i = 1'b0;
    blk_locked_i = 3'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    // slots before any bus reset are ignored
    m.write_byte(OP_REFRESH);
    // read streams and wraps past ffh
    exp_q.push_back({8'h02, 8'hff, 8'h00});
    exp_q.push_back({8'h02, 8'h00, 8'h00});
    start(OP_READ);
    m.write_byte(8'hff);
    m.read_byte(v, rel);
    check("read byte at ff", v, 8'hff ^ 8'ha5);
    check("line released in read slots", rel, 1'b1);
    exp_q.push_back({8'h02, 8'h01, 8'h00});
    m.read_byte(v, rel);
    check("read byte at 00", v, 8'h00 ^ 8'ha5);
    // eeprom byte dropped while busy, next address taken
    copy_busy_flag_i = 1'b1;
    start(OP_WRITE);
    m.write_byte(8'h4f);
    m.write_byte(8'h3c);
    v = 8'($urandom);
    exp_q.push_back({8'h01, 8'h50, v});
    m.write_byte(v);
    // partial byte before reset is never written
    m.write_bit(1'b1);
    m.write_bit(1'b0);
    copy_busy_flag_i = 1'b0;
    cmd(OP_REFRESH, STATUS_INIT_ADDR, 1'b0, 1'b0, 3'h0, 8'h13);
    m.write_byte(OP_READ);
    cmd(OP_CHG_START, 8'h00, 1'b0, 1'b0, 3'h0, 8'h14);
    cmd(OP_CHG_STOP, 8'h00, 1'b0, 1'b0, 3'h0, 8'h15);
    cmd(OP_RECALL, 8'h30, 1'b1, 1'b0, 3'h0, 8'h11);
    cmd(OP_COPY, 8'h40, 1'b1, 1'b0, 3'h0, 8'h10);
    cmd(OP_COPY, 8'h30, 1'b1, 1'b0, 3'h2, 8'h00);
    cmd(OP_LOCK, 8'h20, 1'b1, 1'b1, 3'h0, 8'h12);
    cmd(OP_LOCK, 8'h20, 1'b1, 1'b0, 3'h0, 8'h00);
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(negedge clk_i);
    check("pending notes", 24'(exp_q.size()), 24'h0);
    check("drive level", 24'(dq_o), 24'h0);
    results();
  end
endmodule
